// File: sim/rtcc_ref_model.sv
`timescale 1ns/10ps
// ------------------------------------------------
// precise reference square wave on the window pin
// ------------------------------------------------
module rtcc_ref_model #(
  parameter int HALF = 100  // half period in clk cycles
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // control and pin
  input  wire logic en,
  output logic      ref_window_pin
);
  int cnt_q;  // cycles spent in the current level
  // stays low until enabled, so the first rise follows arming
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q          <= 0;
      ref_window_pin <= 1'b0;
    end else if (!en) begin
      cnt_q          <= 0;
      ref_window_pin <= 1'b0;
    end else if (cnt_q == HALF - 1) begin
      cnt_q          <= 0;
      ref_window_pin <= ~ref_window_pin;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
endmodule

// File: sim/test_rtcc_top.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
// ------------------------------------------------
// bench for snapshot, compare and measurement
// ------------------------------------------------
module test_rtcc_top import rtcc_pkg::*;;
  localparam int HALF = 100;  // reference half period in clk cycles
  logic clk = 0, arst_n = 0, read = 0, write = 0, hf = 0, hf_run = 0, ref_en = 0;
  logic [ADDR_W-1:0] address = '0;
  logic [DATA_W-1:0] writedata = '0, readdata, q;
  logic              waitrequest, sec_tick, ref_pin;
  logic [19:0]       a1, a2, b1, b2, ex;
  int mismatches = 0, cmp_count = 0, cyc = 0, ticks = 0, last_t = 0, gap = 0;
  rtcc_top i_rtcc_top (.clk, .arst_n, .address, .read, .write, .writedata,
    .byteenable(4'h1), .readdata, .waitrequest, .ref_window_pin(ref_pin),
    .hf_src_pin(hf), .lf_src_pin(hf), .sec_tick);
  rtcc_ref_model #(.HALF(HALF)) i_rtcc_ref_model (.clk, .arst_n, .en(ref_en),
    .ref_window_pin(ref_pin));
  always #10 clk = ~clk;
  // source clock, tick spacing and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (hf_run && cyc[0]) hf <= ~hf;
    if (sec_tick === 1'b1) begin
      ticks  <= ticks + 1;
      last_t <= cyc;
      gap    <= cyc - last_t;
    end
    if (cyc == 20000) begin
      mismatches++;
      end_sim;
    end
  end
  // one avalon transfer held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    read <= ~w; write <= w; address <= a; writedata <= {24'h0, d};
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    q = readdata;
    read <= 1'b0; write <= 1'b0;
  endtask
  // low byte first, repeated until two passes agree above the low byte
  task automatic snap(input logic [3:0] b, output logic [19:0] v);
    logic [19:0] p;
    v = 'x;
    repeat (4) begin
      p = v;
      bus(0, b, 8'h00); v[7:0] = q[7:0];
      bus(0, 4'(b + 1), 8'h00); v[15:8] = q[7:0];
      bus(0, 4'(b + 2), 8'h00); v[19:16] = q[3:0];
      if (p[19:8] === v[19:8]) break;
    end
    `CHK("snap_high_top", 4'h0, q[7:4])
  endtask
  task automatic rst;
    arst_n <= 1'b0; repeat (2) @(posedge clk); arst_n <= 1'b1;
  endtask
  task automatic run(input int n);
    hf_run <= 1'b1; repeat (n) @(posedge clk); hf_run <= 1'b0; repeat (8) @(posedge clk);
  endtask
  task automatic wait_tick;
    int n;
    n = ticks;
    repeat (3000) if (ticks == n) @(posedge clk);
  endtask
  // reset values, then an unmapped place
  task automatic t_reset;
    logic [7:0] e [0:6];
    e = '{8'hFF, 8'hFF, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h00};
    bus(1, 4'hD, 8'h55);
    for (int i = 0; i < 7; i++) begin
      bus(0, 4'(IDX_CMPL + i), 8'h00);
      `CHK("reset_val", e[i], q[7:0])
    end
    bus(0, 4'hD, 8'h00);
    `CHK("unmapped", 32'h0, q)
  endtask
  // counter 1 snapshot holds until the low byte is read again
  task automatic t_snap;
    bus(1, IDX_CTL1, 8'h01); bus(1, IDX_CTL2, 8'h01);
    run(200); snap(IDX_C1L, a1); snap(IDX_C2L, a2); run(1200);
    bus(0, IDX_C1M, 8'h00);
    `CHK("c1_mid_held", a1[15:8], q[7:0])
    bus(0, IDX_C1H, 8'h00);
    `CHK("c1_high_held", {4'h0, a1[19:16]}, q[7:0])
    snap(IDX_C1L, b1);
    `CHK("c1_capture", a1 + 20'd300, b1)
    snap(IDX_C2L, b2);
    `CHK("c2_capture", a2 + 20'd300, b2)
    bus(1, IDX_CTL1, 8'h00); bus(1, IDX_CTL2, 8'h00);
  endtask
  // second length: immediate when stopped, buffered while running
  task automatic t_clock;
    rst;
    bus(1, IDX_CMPL, 8'h03); bus(1, IDX_CMPM, 8'h00); bus(1, IDX_CMPH, 8'h00);
    bus(1, IDX_CTL1, 8'h01); hf_run <= 1'b1;
    wait_tick; wait_tick;
    `CHK("gap_first", 16, gap)
    bus(1, IDX_CMPL, 8'h07);
    wait_tick;
    `CHK("gap_old", 16, gap)
    wait_tick;
    `CHK("gap_new", 32, gap)
    hf_run <= 1'b0; bus(1, IDX_CTL1, 8'h00);
  endtask
  // every window width against the external reference
  task automatic t_measure;
    for (int s = 0; s < 4; s++) begin
      rst;
      bus(1, IDX_CTL2, 8'(s << 3));
      bus(1, IDX_CTL1, 8'h03);
      bus(0, IDX_STAT, 8'h00);
      `CHK("armed", 8'h05, q[7:0])
      hf_run <= 1'b1; ref_en <= 1'b1;
      repeat (3000) if (q[0] !== 1'b0) bus(0, IDX_STAT, 8'h00);
      `CHK("done", 8'h00, q[7:0])
      ref_en <= 1'b0; hf_run <= 1'b0; bus(1, IDX_CTL1, 8'h00);
      snap(IDX_C1L, a1);
      ex = (s == 0) ? 20'(HALF / 4) : 20'((HALF / 2) << (2 * s - 2));
      `CHK("window", 1'b1, (a1 + 20'h2 >= ex) && (a1 <= ex + 20'h2))
    end
  endtask
  // counter 2 trimmed over 16 seconds of counter 1 output, 16 cycles each
  task automatic t_trim;
    rst;
    bus(1, IDX_CMPL, 8'h03); bus(1, IDX_CMPM, 8'h00); bus(1, IDX_CMPH, 8'h00);
    bus(1, IDX_CTL2, 8'h1F);
    bus(0, IDX_STAT, 8'h00);
    `CHK("trim_armed", 8'h0A, q[7:0])
    bus(1, IDX_CTL1, 8'h01); hf_run <= 1'b1;
    repeat (3000) if (q[1] !== 1'b0) bus(0, IDX_STAT, 8'h00);
    `CHK("trim_done", 8'h01, q[7:0])
    hf_run <= 1'b0; bus(1, IDX_CTL1, 8'h00); bus(1, IDX_CTL2, 8'h00);
    snap(IDX_C2L, a2);
    `CHK("trim_count", 1'b1, (a2 + 20'h2 >= 20'd64) && (a2 <= 20'd66))
  endtask
  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    t_reset; t_snap; t_clock; t_measure; t_trim;
    end_sim;
  end
endmodule

// File: src/rtcc_cmp.sv
`timescale 1ns/10ps
module rtcc_cmp import rtcc_pkg::*; #(
  parameter int NB = NBYTES
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // write side
  input  wire logic [NB-1:0]    byte_wr,
  input  wire logic [BYTE_W-1:0] wdata,
  input  wire logic             load,
  // buffer and active values
  output logic      [CNT_W-1:0] buf_val,
  output logic      [CNT_W-1:0] act_val
);

  // ----------------------------------------------------------------
  // two-stage compare register
  // ----------------------------------------------------------------
  localparam int                 VW    = NB * BYTE_W;
  localparam logic [CNT_W-1:0]   ONES  = '1;
  localparam logic [VW-1:0]      VMASK = VW'(ONES);     // implemented bits
  localparam logic [VW-1:0]      VRST  = VW'(CMP_RST);

  logic [VW-1:0] buf_q;  // software-written stage
  logic [VW-1:0] act_q;  // stage compared with counter 1

  if (VW < CNT_W) begin : g_chk
    $error("rtcc_cmp: NB bytes do not cover the counter width");
  end

  for (genvar k = 0; k < NB; k++) begin : g_byte
    // each byte moves on its own, so a half-done update mixes bytes
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        buf_q[k*BYTE_W +: BYTE_W] <= VRST[k*BYTE_W +: BYTE_W];
        act_q[k*BYTE_W +: BYTE_W] <= VRST[k*BYTE_W +: BYTE_W];
      end else begin
        if (byte_wr[k]) begin
          buf_q[k*BYTE_W +: BYTE_W] <= wdata & VMASK[k*BYTE_W +: BYTE_W];
        end
        if (load) begin
          // taken over on a match or whenever stopped
          act_q[k*BYTE_W +: BYTE_W] <= buf_q[k*BYTE_W +: BYTE_W];
        end
      end
    end
  end

  assign buf_val = buf_q[CNT_W-1:0];
  assign act_val = act_q[CNT_W-1:0];

endmodule

// File: src/rtcc_pkg.sv
package rtcc_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int CNT_W  = 20;               // prescale counter width
  localparam int BYTE_W = 8;                // register data width
  localparam int NBYTES = 3;                // bytes per counter value
  localparam int ADDR_W = 4;                // word address width
  localparam int DATA_W = 32;               // bus data width

  // ----------------------------------------------------------------
  // register word indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] IDX_C1L  = 4'h0;  // cnt1_snap_low
  localparam logic [ADDR_W-1:0] IDX_C1M  = 4'h1;  // cnt1_snap_mid
  localparam logic [ADDR_W-1:0] IDX_C1H  = 4'h2;  // cnt1_snap_high
  localparam logic [ADDR_W-1:0] IDX_C2L  = 4'h3;  // cnt2_snap_low
  localparam logic [ADDR_W-1:0] IDX_C2M  = 4'h4;  // cnt2_snap_mid
  localparam logic [ADDR_W-1:0] IDX_C2H  = 4'h5;  // cnt2_snap_high
  localparam logic [ADDR_W-1:0] IDX_CMPL = 4'h6;  // second_cmp_low
  localparam logic [ADDR_W-1:0] IDX_CMPM = 4'h7;  // second_cmp_mid
  localparam logic [ADDR_W-1:0] IDX_CMPH = 4'h8;  // second_cmp_high
  localparam logic [ADDR_W-1:0] IDX_CTL1 = 4'h9;  // clock_ctrl_one
  localparam logic [ADDR_W-1:0] IDX_CTL2 = 4'hA;  // clock_ctrl_two
  localparam logic [ADDR_W-1:0] IDX_STAT = 4'hB;  // clock_state_reg

  // byte lane numbers inside a counter value
  localparam logic [1:0] BYTE_L = 2'h0;
  localparam logic [1:0] BYTE_M = 2'h1;
  localparam logic [1:0] BYTE_H = 2'h2;

  // ----------------------------------------------------------------
  // reset values and window settings
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] CMP_RST = 20'hFFFFF;  // full count
  localparam logic [1:0] WSEL_DIRECT = 2'h0;         // window = input level
  localparam logic [1:0] WSEL_1S     = 2'h1;
  localparam logic [1:0] WSEL_4S     = 2'h2;
  localparam logic [1:0] WSEL_16S    = 2'h3;
  localparam logic [4:0] EDGES_1S    = 5'h01;        // reference periods
  localparam logic [4:0] EDGES_4S    = 5'h04;
  localparam logic [4:0] EDGES_16S   = 5'h10;

  // ----------------------------------------------------------------
  // register layouts, bit 0 first from the right
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cnt1_measure_en;
    logic cnt1_run_en;
  } rtcc_ctrl1_s;

  typedef struct packed {
    logic [1:0] window_width_sel;
    logic       ref_input_select;
    logic       cnt2_measure_en;
    logic       cnt2_run_en;
  } rtcc_ctrl2_s;

  typedef struct packed {
    logic cnt2_measure_active;
    logic cnt1_measure_active;
    logic cnt2_running_flag;
    logic cnt1_running_flag;
  } rtcc_stat_s;

  localparam rtcc_ctrl1_s CTRL1_RST = '0;
  localparam rtcc_ctrl2_s CTRL2_RST = '0;

  // window generator states
  typedef enum logic [1:0] {
    WIN_IDLE = 2'b00,
    WIN_WAIT = 2'b01,
    WIN_OPEN = 2'b10,
    WIN_DONE = 2'b11
  } rtcc_win_e;

endpackage

// File: src/rtcc_sync.sv
`timescale 1ns/10ps
module rtcc_sync import rtcc_pkg::*; #(
  parameter int W = 3
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  // pins and synchronised copies
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  // ----------------------------------------------------------------
  // two flip-flop synchroniser
  // ----------------------------------------------------------------
  logic [W-1:0] meta_q;  // first stage, read only by the second

  if (W < 1) begin : g_chk
    $error("rtcc_sync: W must be at least 1");
  end

  // both stages reset to low
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// File: src/rtcc_top.sv
`timescale 1ns/10ps
// Function
// - low read captures all counter 1 bytes
// - counter 1 snapshot changes only on low read
// - low read captures all counter 2 bytes
// - compare value double-buffered, loads at match
// - stopped clock: compare write applies immediately
// - compare bytes transfer together at match
// - reset sets compare to full count
// - measurement counts only while window high
// - select bit zero picks external reference
// - width field picks direct, 1, 4, 16 s
// - counter 1 output can window counter 2
// - window fall clears running flag, stops counter
// - up to one clock error per edge
// - 20-bit counters, match advances seconds
// - high snapshot bits 7..4 read zero
module rtcc_top import rtcc_pkg::*; (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              arst_n,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [DATA_W-1:0] writedata,
  input  wire logic [3:0]        byteenable,
  output logic      [DATA_W-1:0] readdata,
  output logic                   waitrequest,
  // pins
  input  wire logic              ref_window_pin,
  input  wire logic              hf_src_pin,
  input  wire logic              lf_src_pin,
  // towards the calendar
  output logic                   sec_tick
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [2:0]        pins_s;          // synchronised {ref, hf, lf}
  logic [2:0]        pins_prev_q;     // previous synchronised levels
  logic              hf_tick;         // source edge for counter 1
  logic              lf_tick;         // source edge for counter 2
  logic              waitrequest_q;   // bus wait state
  logic [DATA_W-1:0] readdata_q;      // registered read data
  logic [BYTE_W-1:0] rd_d;            // read mux
  logic              rd_acc;          // read taken this edge
  logic              wr_take;         // write completes this edge
  rtcc_ctrl1_s       ctrl1_q;         // clock_ctrl_one
  rtcc_ctrl2_s       ctrl2_q;         // clock_ctrl_two
  rtcc_stat_s        stat;            // clock_state_reg view
  logic              done1_q;         // counter 1 measurement ended
  logic              done2_q;         // counter 2 measurement ended
  logic [CNT_W-1:0]  cnt1_q;          // prescale counter 1
  logic [CNT_W-1:0]  cnt2_q;          // prescale counter 2
  logic [CNT_W-1:0]  snap1_q;         // counter 1 snapshot
  logic [CNT_W-1:0]  snap2_q;         // counter 2 snapshot
  logic [CNT_W-1:0]  cmp_buf;         // written compare value
  logic [CNT_W-1:0]  cmp_act;         // active compare value
  logic [NBYTES-1:0] cmp_wr;          // compare byte write strobes
  logic              match1;          // one-second match
  logic              ovf1;            // counter 1 wrap in measurement
  logic              step1;           // counter 1 counts
  logic              step2;           // counter 2 counts
  logic              sec_tick_q;      // seconds pulse
  logic              sec_lvl_q;       // counter 1 output level
  rtcc_win_e         win_q;           // window generator state
  rtcc_win_e         win_d;
  logic [4:0]        ecnt_q;          // reference periods seen
  logic [4:0]        ecnt_d;
  logic              window;          // window pulse high
  logic              win_end;         // window falls
  logic              arm;             // some counter waits to measure
  logic              ref_lvl;         // selected window source level
  logic              ref_rise;        // selected window source edge

  // byte k of a counter value, unused high bits zero
  function automatic logic [BYTE_W-1:0] byte_of(input logic [CNT_W-1:0] v,
                                                input logic [1:0] k);
    logic [NBYTES*BYTE_W-1:0] w;
    w       = (NBYTES*BYTE_W)'(v);
    byte_of = w[{k, 3'h0} +: BYTE_W];
  endfunction

  // reference periods that make up one window
  function automatic logic [4:0] width_edges(input logic [1:0] sel);
    case (sel)
      WSEL_4S:  width_edges = EDGES_4S;
      WSEL_16S: width_edges = EDGES_16S;
      default:  width_edges = EDGES_1S;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  rtcc_sync #(.W(3)) u_sync (
    .clk      (clk),
    .arst_n   (arst_n),
    .async_in ({ref_window_pin, hf_src_pin, lf_src_pin}),
    .sync_out (pins_s)
  );

  // previous levels for rising edges
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pins_prev_q <= '0;
    end else begin
      pins_prev_q <= pins_s;
    end
  end

  assign hf_tick = pins_s[1] & ~pins_prev_q[1];
  assign lf_tick = pins_s[0] & ~pins_prev_q[0];

  // ----------------------------------------------------------------
  // avalon-mm slave: one wait cycle, then the answer
  // ----------------------------------------------------------------
  assign rd_acc  = read & waitrequest_q;
  assign wr_take = write & ~waitrequest_q & byteenable[0];

  // wait state drops for exactly one cycle per request
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      waitrequest_q <= 1'b1;
    end else begin
      waitrequest_q <= ~((read | write) & waitrequest_q);
    end
  end

  // read mux, low bytes come live so they match the capture
  always_comb begin
    case (address)
      IDX_C1L:  rd_d = byte_of(cnt1_q, BYTE_L);
      IDX_C1M:  rd_d = byte_of(snap1_q, BYTE_M);
      IDX_C1H:  rd_d = byte_of(snap1_q, BYTE_H);
      IDX_C2L:  rd_d = byte_of(cnt2_q, BYTE_L);
      IDX_C2M:  rd_d = byte_of(snap2_q, BYTE_M);
      IDX_C2H:  rd_d = byte_of(snap2_q, BYTE_H);
      IDX_CMPL: rd_d = byte_of(cmp_buf, BYTE_L);
      IDX_CMPM: rd_d = byte_of(cmp_buf, BYTE_M);
      IDX_CMPH: rd_d = byte_of(cmp_buf, BYTE_H);
      IDX_CTL1: rd_d = BYTE_W'(ctrl1_q);
      IDX_CTL2: rd_d = BYTE_W'(ctrl2_q);
      IDX_STAT: rd_d = BYTE_W'(stat);
      default:  rd_d = '0;                         // unmapped reads zero
    endcase
  end

  // read data held until the next read
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      readdata_q <= '0;
    end else if (rd_acc) begin
      readdata_q <= DATA_W'(rd_d);
    end
  end

  // snapshots move only on a low-byte read
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      snap1_q <= '0;
      snap2_q <= '0;
    end else if (rd_acc) begin
      if (address == IDX_C1L) begin
        snap1_q <= cnt1_q;
      end
      if (address == IDX_C2L) begin
        snap2_q <= cnt2_q;
      end
    end
  end

  // control registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl1_q <= CTRL1_RST;
      ctrl2_q <= CTRL2_RST;
    end else if (wr_take) begin
      if (address == IDX_CTL1) begin
        ctrl1_q <= rtcc_ctrl1_s'(writedata[$bits(rtcc_ctrl1_s)-1:0]);
      end
      if (address == IDX_CTL2) begin
        ctrl2_q <= rtcc_ctrl2_s'(writedata[$bits(rtcc_ctrl2_s)-1:0]);
      end
    end
  end

  // ----------------------------------------------------------------
  // compare register
  // ----------------------------------------------------------------
  assign cmp_wr = {wr_take & (address == IDX_CMPH),
                   wr_take & (address == IDX_CMPM),
                   wr_take & (address == IDX_CMPL)};

  rtcc_cmp #(.NB(NBYTES)) u_cmp (
    .clk     (clk),
    .arst_n  (arst_n),
    .byte_wr (cmp_wr),
    .wdata   (writedata[BYTE_W-1:0]),
    .load    (match1 | ~stat.cnt1_running_flag),
    .buf_val (cmp_buf),
    .act_val (cmp_act)
  );

  // ----------------------------------------------------------------
  // run and measurement flags
  // ----------------------------------------------------------------
  assign stat.cnt1_running_flag   = ctrl1_q.cnt1_run_en & ~done1_q;
  assign stat.cnt2_running_flag   = ctrl2_q.cnt2_run_en & ~done2_q;
  assign stat.cnt1_measure_active = stat.cnt1_running_flag & ctrl1_q.cnt1_measure_en;
  assign stat.cnt2_measure_active = stat.cnt2_running_flag & ctrl2_q.cnt2_measure_en;

  // end of window stops a measuring counter until its enable drops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      done1_q <= 1'b0;
      done2_q <= 1'b0;
    end else begin
      if (win_end & stat.cnt1_measure_active) begin
        done1_q <= 1'b1;
      end else if (!ctrl1_q.cnt1_run_en) begin
        done1_q <= 1'b0;
      end
      if (win_end & stat.cnt2_measure_active) begin
        done2_q <= 1'b1;
      end else if (!ctrl2_q.cnt2_run_en) begin
        done2_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // window pulse generator
  // ----------------------------------------------------------------
  // select zero takes the pin, one takes counter 1 output
  assign ref_lvl  = ctrl2_q.ref_input_select ? sec_lvl_q : pins_s[2];
  assign ref_rise = ctrl2_q.ref_input_select ? sec_tick_q
                                             : (pins_s[2] & ~pins_prev_q[2]);
  assign arm      = stat.cnt1_measure_active | stat.cnt2_measure_active;
  assign window   = (win_q == WIN_OPEN);
  assign win_end  = (win_q == WIN_OPEN) & (win_d == WIN_DONE);

  // next state: direct follows the level, others count periods
  always_comb begin
    win_d  = win_q;
    ecnt_d = ecnt_q;
    case (win_q)
      WIN_IDLE: begin
        if (arm) begin
          win_d = WIN_WAIT;
        end
      end
      WIN_WAIT: begin
        ecnt_d = '0;
        if (!arm) begin
          win_d = WIN_IDLE;
        end else if (ctrl2_q.window_width_sel == WSEL_DIRECT ? ref_lvl : ref_rise) begin
          win_d = WIN_OPEN;
        end
      end
      WIN_OPEN: begin
        if (!arm) begin
          win_d = WIN_IDLE;
        end else if (ctrl2_q.window_width_sel == WSEL_DIRECT) begin
          if (!ref_lvl) begin
            win_d = WIN_DONE;
          end
        end else if (ref_rise) begin
          ecnt_d = 5'(ecnt_q + 5'h01);
          if (ecnt_d == width_edges(ctrl2_q.window_width_sel)) begin
            win_d = WIN_DONE;
          end
        end
      end
      WIN_DONE: begin
        if (!arm) begin
          win_d = WIN_IDLE;
        end
      end
      default: win_d = WIN_IDLE;
    endcase
  end

  // window state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      win_q  <= WIN_IDLE;
      ecnt_q <= '0;
    end else begin
      win_q  <= win_d;
      ecnt_q <= ecnt_d;
    end
  end

  // ----------------------------------------------------------------
  // prescale counters
  // ----------------------------------------------------------------
  // a source edge near a window edge may be lost or gained
  assign step1  = stat.cnt1_running_flag & hf_tick
                & (~ctrl1_q.cnt1_measure_en | window);
  assign step2  = stat.cnt2_running_flag & lf_tick
                & (~ctrl2_q.cnt2_measure_en | window);
  assign match1 = stat.cnt1_running_flag & ~ctrl1_q.cnt1_measure_en & hf_tick & (cnt1_q == cmp_act);
  assign ovf1   = step1 & ctrl1_q.cnt1_measure_en & (&cnt1_q);

  // counter 1 restarts after each one-second match
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt1_q <= '0;
    end else if (match1) begin
      cnt1_q <= '0;
    end else if (step1) begin
      cnt1_q <= CNT_W'(cnt1_q + 1'b1);
    end
  end

  // counter 2 wraps freely
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt2_q <= '0;
    end else if (step2) begin
      cnt2_q <= CNT_W'(cnt2_q + 1'b1);
    end
  end

  // seconds pulse and counter 1 output level
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sec_tick_q <= 1'b0;
      sec_lvl_q  <= 1'b0;
    end else begin
      sec_tick_q <= match1 | ovf1;
      sec_lvl_q  <= sec_lvl_q ^ match1;
    end
  end

  assign readdata    = readdata_q;
  assign waitrequest = waitrequest_q;
  assign sec_tick    = sec_tick_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_snap1_cap;
    @(posedge clk) disable iff (!arst_n)
    (rd_acc && address == IDX_C1L) |=> (snap1_q == $past(cnt1_q));
  endproperty
  a_snap1_cap: assert property (p_snap1_cap) else $error("cnt1 snapshot missed");

  property p_snap1_hold;
    @(posedge clk) disable iff (!arst_n)
    !(rd_acc && address == IDX_C1L) |=> $stable(snap1_q);
  endproperty
  a_snap1_hold: assert property (p_snap1_hold) else $error("cnt1 snapshot moved");

  property p_snap2_cap;
    @(posedge clk) disable iff (!arst_n)
    (rd_acc && address == IDX_C2L) |=> (snap2_q == $past(cnt2_q));
  endproperty
  a_snap2_cap: assert property (p_snap2_cap) else $error("cnt2 snapshot missed");

  property p_cmp_hold;
    @(posedge clk) disable iff (!arst_n)
    (stat.cnt1_running_flag && !match1) |=> $stable(cmp_act);
  endproperty
  a_cmp_hold: assert property (p_cmp_hold) else $error("compare changed without match");

  property p_cmp_idle;
    @(posedge clk) disable iff (!arst_n)
    (!stat.cnt1_running_flag && cmp_wr[0]) |=>
      ##1 (cmp_act[BYTE_W-1:0] == $past(writedata[BYTE_W-1:0], 2));
  endproperty
  a_cmp_idle: assert property (p_cmp_idle) else $error("stopped write not applied");

  property p_gate;
    @(posedge clk) disable iff (!arst_n)
    (ctrl1_q.cnt1_measure_en && !window) |=> $stable(cnt1_q);
  endproperty
  a_gate: assert property (p_gate) else $error("cnt1 counted outside window");

  property p_end_stop;
    @(posedge clk) disable iff (!arst_n)
    (win_end && stat.cnt1_measure_active) |=> !stat.cnt1_running_flag ##1 $stable(cnt1_q);
  endproperty
  a_end_stop: assert property (p_end_stop) else $error("cnt1 ran after window end");

  property p_match;
    @(posedge clk) disable iff (!arst_n)
    match1 |=> (cnt1_q == '0) && sec_tick;
  endproperty
  a_match: assert property (p_match) else $error("match did not restart second");

  property p_high_zero;
    @(posedge clk) disable iff (!arst_n)
    (rd_acc && (address == IDX_C1H || address == IDX_C2H)) |=> (readdata[7:4] == 4'h0);
  endproperty
  a_high_zero: assert property (p_high_zero) else $error("high snapshot top bits set");

endmodule
